// File: pmx_consts.svh
// pmx_consts.svh
// addresses, geometry and per-ball tables of the pad function mux
// assumes inclusion by bare name from the pad mux package and modules
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// ============================================================
// geometry
`define PMX_N_BALLS        10
`define PMX_MODE_W         4
`define PMX_N_MODES        16
`define PMX_CTRL_W         11
`define PMX_BUS_W          32
`define PMX_MODE_DEFAULT   4'h0

// ============================================================
// control word addresses, one aligned word per ball
`define PMX_ADDR_HOST_ATTN 32'hffffea00
`define PMX_ADDR_B_DOUT    32'hffffea1c
`define PMX_ADDR_B_DIN     32'hffffea20
`define PMX_ADDR_WARM_RST  32'hffffea48
`define PMX_ADDR_TCLK      32'hffffea50
`define PMX_ADDR_TMS       32'hffffea54
`define PMX_ADDR_TDI       32'hffffea58
`define PMX_ADDR_TDO       32'hffffea5c
`define PMX_ADDR_SYNC_IN   32'hffffea6c
`define PMX_ADDR_SYNC_OUT  32'hffffea70
`define PMX_ADDR_STATUS    32'hffffeaf0
`define PMX_STAT_STRAP_LSB 16

// ============================================================
// strap balls
`define PMX_BALL_TDO       7
`define PMX_BALL_SYNC_OUT  9

// ============================================================
// per ball: {legal modes, output-only modes, input-only modes, has pull, reset word}
`define PMX_MAP_HOST_ATTN  {16'h0047, 16'h0006, 16'h0000, 1'b1, 11'h040}
`define PMX_MAP_B_DOUT     {16'h0007, 16'h0000, 16'h0000, 1'b1, 11'h240}
`define PMX_MAP_B_DIN      {16'h0047, 16'h0040, 16'h0000, 1'b1, 11'h240}
`define PMX_MAP_WARM_RST   {16'h0001, 16'h0000, 16'h0000, 1'b0, 11'h140}
`define PMX_MAP_TCLK       {16'h0107, 16'h0104, 16'h0002, 1'b1, 11'h040}
`define PMX_MAP_TMS        {16'h0047, 16'h0004, 16'h0042, 1'b1, 11'h040}
`define PMX_MAP_TDI        {16'h0007, 16'h0000, 16'h0006, 1'b1, 11'h240}
`define PMX_MAP_TDO        {16'h02c7, 16'h00c6, 16'h0200, 1'b0, 11'h1c0}
`define PMX_MAP_SYNC_IN    {16'h02c3, 16'h0200, 16'h0082, 1'b1, 11'h040}
`define PMX_MAP_SYNC_OUT   {16'h0e03, 16'h0002, 16'h0200, 1'b1, 11'h040}

`endif

// File: pmx_pkg.sv
// pmx_pkg.sv
// types shared by the pad function mux modules
// assumes pmx_consts.svh on the include path
`include "pmx_consts.svh"

package pmx_pkg;

    // ============================================================
    // one ball's control word, msb first
    typedef struct packed {
        logic                   slew_slow_select;
        logic                   pull_direction_select;
        logic                   pull_disable;
        logic                   oe_forced_value;
        logic                   oe_force;
        logic                   input_forced_value;
        logic                   input_force;
        logic [`PMX_MODE_W-1:0] function_select_field;
    } pmx_ctrl_t;

    // static description of one ball
    typedef struct packed {
        logic [`PMX_N_MODES-1:0] valid;
        logic [`PMX_N_MODES-1:0] out_only;
        logic [`PMX_N_MODES-1:0] in_only;
        logic                    has_pull;
        pmx_ctrl_t               rst_word;
    } pmx_ball_map_t;

    // drive offered to one ball by its peripherals, indexed by mode
    typedef struct packed {
        logic [`PMX_N_MODES-1:0] dout;
        logic [`PMX_N_MODES-1:0] doe;
    } pmx_periph_t;

    // pad controls of one ball
    typedef struct packed {
        logic dout;
        logic oe;
        logic pull_en;
        logic pull_up;
        logic slew_slow;
    } pmx_pad_t;

endpackage : pmx_pkg

// File: pmx_sync3.sv
// pmx_sync3.sv
// three-flop synchroniser with agreement filter for ball levels
// assumes d is asynchronous to clk; q holds until stages two and three agree
`timescale 1ns/10ps

module pmx_sync3 #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk,
    // levels
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    if (W < 1) begin : g_bad_w
        $error("pmx_sync3 needs W of one or more");
    end

    // ============================================================
    // no reset so straps can be seen while reset is held
    always_ff @(posedge clk) begin
        s1_q <= d;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        q <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
    end

endmodule : pmx_sync3

// File: pmx_pad_cell.sv
// pmx_pad_cell.sv
// one ball: mode routing, overrides, pull and slew, all outputs registered
// assumes ctrl and periph come from the clk domain and level is synchronised
`timescale 1ns/10ps

`include "pmx_consts.svh"

module pmx_pad_cell #(
    parameter pmx_pkg::pmx_ball_map_t MAP = '0
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // control and peripherals
    input  wire pmx_pkg::pmx_ctrl_t        ctrl,
    input  wire pmx_pkg::pmx_periph_t      periph,
    output      logic [`PMX_N_MODES-1:0]   periph_in,
    // ball
    input  wire logic                      level,
    output      pmx_pkg::pmx_pad_t         pad
);

    logic [`PMX_MODE_W-1:0]  mode;
    logic                    sel_ok;
    logic                    in_val;
    logic [`PMX_N_MODES-1:0] hot;
    pmx_pkg::pmx_pad_t       pad_d;
    logic [`PMX_N_MODES-1:0] pin_d;

    // ============================================================
    // routing from the low four bits of the control word
    assign mode   = ctrl.function_select_field;
    assign sel_ok = MAP.valid[mode];
    assign hot    = {{(`PMX_N_MODES-1){1'b0}}, 1'b1} << mode;
    assign in_val = ctrl.input_force ? ctrl.input_forced_value : level;

    // illegal mode leaves the ball undriven even under override
    always_comb begin
        pad_d           = '0;
        pad_d.slew_slow = ctrl.slew_slow_select;
        pad_d.pull_en   = MAP.has_pull & ~ctrl.pull_disable;
        pad_d.pull_up   = pad_d.pull_en & ctrl.pull_direction_select;
        if (!sel_ok) begin
            pad_d.oe = 1'b0;
        end else if (ctrl.oe_force) begin
            pad_d.oe = ctrl.oe_forced_value;
        end else if (MAP.out_only[mode]) begin
            pad_d.oe = 1'b1;
        end else if (MAP.in_only[mode]) begin
            pad_d.oe = 1'b0;
        end else begin
            pad_d.oe = periph.doe[mode];
        end
        pad_d.dout = sel_ok & periph.dout[mode];
        pin_d      = (sel_ok && !MAP.out_only[mode]) ? (hot & {`PMX_N_MODES{in_val}}) : '0;
    end

    // pads float and peripheral inputs idle low while reset is held
    always_ff @(posedge clk) begin
        if (rst) begin
            pad       <= '0;
            periph_in <= '0;
        end else begin
            pad       <= pad_d;
            periph_in <= pin_d;
        end
    end

endmodule : pmx_pad_cell

// File: pmx_pad_mux.sv
// pmx_pad_mux.sv
// pad function mux for ten balls: control words, routing, straps, status
// assumes a single-cycle register port and raw ball levels from the pads
`timescale 1ns/10ps

`include "pmx_consts.svh"

module pmx_pad_mux #(
    parameter int N_BALLS = `PMX_N_BALLS
) (
    // clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    rst,
    // register port
    input  wire logic [`PMX_BUS_W-1:0]                   reg_addr,
    input  wire logic [`PMX_BUS_W-1:0]                   reg_wdata,
    input  wire logic                                    reg_wr,
    input  wire logic                                    reg_rd,
    output      logic [`PMX_BUS_W-1:0]                   reg_rdata,
    // peripheral side, one entry per ball, bit per mode
    input  wire pmx_pkg::pmx_periph_t [N_BALLS-1:0]      periph_drv,
    output      logic [N_BALLS-1:0][`PMX_N_MODES-1:0]    periph_in,
    // ball side
    input  wire logic [N_BALLS-1:0]                      pad_level_in,
    output      pmx_pkg::pmx_pad_t [N_BALLS-1:0]         pad_ctl,
    // boot straps
    output      logic                                    boot_option_strap_zero,
    output      logic                                    boot_option_strap_one
);

    // ============================================================
    // ball tables
    localparam logic [`PMX_BUS_W-1:0] BALL_ADDR [N_BALLS] = '{
        `PMX_ADDR_HOST_ATTN,
        `PMX_ADDR_B_DOUT,
        `PMX_ADDR_B_DIN,
        `PMX_ADDR_WARM_RST,
        `PMX_ADDR_TCLK,
        `PMX_ADDR_TMS,
        `PMX_ADDR_TDI,
        `PMX_ADDR_TDO,
        `PMX_ADDR_SYNC_IN,
        `PMX_ADDR_SYNC_OUT
    };

    // legal modes, direction of each mode, pull presence, reset word
    localparam pmx_pkg::pmx_ball_map_t BALL_MAP [N_BALLS] = '{
        `PMX_MAP_HOST_ATTN,
        `PMX_MAP_B_DOUT,
        `PMX_MAP_B_DIN,
        `PMX_MAP_WARM_RST,
        `PMX_MAP_TCLK,
        `PMX_MAP_TMS,
        `PMX_MAP_TDI,
        `PMX_MAP_TDO,
        `PMX_MAP_SYNC_IN,
        `PMX_MAP_SYNC_OUT
    };

    localparam int PAD_W = `PMX_BUS_W - `PMX_CTRL_W;

    // the tables above hold exactly ten balls
    if (N_BALLS != `PMX_N_BALLS) begin : g_bad_balls
        $error("pmx_pad_mux serves exactly ten balls");
    end

    // ============================================================
    // state
    pmx_pkg::pmx_ctrl_t    ctrl_q [N_BALLS];
    logic [N_BALLS-1:0]    pad_sync;
    logic [`PMX_BUS_W-1:0] status_w;
    logic [`PMX_BUS_W-1:0] rdata_d;

    // ============================================================
    // ball level synchronisers
    pmx_sync3 #(
        .W (N_BALLS)
    ) u_sync (
        .clk (clk),
        .d   (pad_level_in),
        .q   (pad_sync)
    );

    // ============================================================
    // control words; reserved upper bits are not stored and read zero
    always_ff @(posedge clk) begin
        for (int i = 0; i < N_BALLS; i++) begin
            if (rst) begin
                ctrl_q[i] <= BALL_MAP[i].rst_word;
            end else if (reg_wr && reg_addr == BALL_ADDR[i]) begin
                ctrl_q[i] <= pmx_pkg::pmx_ctrl_t'(reg_wdata[`PMX_CTRL_W-1:0]);
            end
        end
    end

    // ============================================================
    // one cell per ball does routing, overrides, pull and slew
    for (genvar b = 0; b < N_BALLS; b++) begin : g_ball
        pmx_pad_cell #(
            .MAP (BALL_MAP[b])
        ) u_cell (
            .clk       (clk),
            .rst       (rst),
            .ctrl      (ctrl_q[b]),
            .periph    (periph_drv[b]),
            .periph_in (periph_in[b]),
            .level     (pad_sync[b]),
            .pad       (pad_ctl[b])
        );
    end

    // ============================================================
    // straps follow the ball while reset is held, then freeze
    // the last value seen before release is the one boot logic keeps
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_option_strap_zero <= pad_sync[`PMX_BALL_TDO];
            boot_option_strap_one  <= pad_sync[`PMX_BALL_SYNC_OUT];
        end
    end

    // ============================================================
    // status word: synchronised ball levels and held straps
    always_comb begin
        status_w                                = '0;
        status_w[N_BALLS-1:0]                   = pad_sync;
        status_w[`PMX_STAT_STRAP_LSB]           = boot_option_strap_zero;
        status_w[`PMX_STAT_STRAP_LSB + 1]       = boot_option_strap_one;
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        if (reg_addr == `PMX_ADDR_STATUS) begin
            rdata_d = status_w;
        end else begin
            for (int i = 0; i < N_BALLS; i++) begin
                if (reg_addr == BALL_ADDR[i]) begin
                    rdata_d = {{PAD_W{1'b0}}, ctrl_q[i]};
                end
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= '0;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    // a write followed by a read of the same word
    sequence s_wr_host;
        reg_wr && reg_addr == `PMX_ADDR_HOST_ATTN;
    endsequence

    sequence s_rd_host;
        reg_rd && !reg_wr && reg_addr == `PMX_ADDR_HOST_ATTN;
    endsequence

    a_write_read_back: assert property (
        s_wr_host ##1 s_rd_host |=>
            reg_rdata == {{PAD_W{1'b0}}, $past(reg_wdata[`PMX_CTRL_W-1:0], 2)}
    ) else $error("control word did not read back as written");

    // only the low four bits pick the mode
    a_mode_low_bits: assert property (
        (ctrl_q[6].function_select_field == 4'h2 && !ctrl_q[6].input_force) |=>
            (periph_in[6][2] == $past(pad_sync[6])) && ($countones(periph_in[6]) <= 1)
    ) else $error("test data in mode two not routed to its receiver");

    a_mode_zero_gpio: assert property (
        (ctrl_q[0].function_select_field == `PMX_MODE_DEFAULT && !ctrl_q[0].oe_force) |=>
            (pad_ctl[0].oe == $past(periph_drv[0].doe[0]))
            && (pad_ctl[0].dout == $past(periph_drv[0].dout[0]))
    ) else $error("mode zero does not route the default signal");

    // first cycle after release shows the listed reset states
    a_reset_state: assert property (
        $past(rst) |=>
            pad_ctl[7].oe && !pad_ctl[7].pull_en
            && !pad_ctl[2].oe && pad_ctl[2].pull_up
            && !pad_ctl[4].oe && pad_ctl[4].pull_en && !pad_ctl[4].pull_up
            && !pad_ctl[3].oe && !pad_ctl[3].pull_en
    ) else $error("ball reset state wrong after reset release");

    a_no_pull_balls: assert property (
        !pad_ctl[3].pull_en && !pad_ctl[7].pull_en
    ) else $error("a ball without a pull shows one");

    a_port_b_din_map: assert property (
        (ctrl_q[2].function_select_field == 4'h6 && !ctrl_q[2].oe_force) |=>
            pad_ctl[2].oe && (pad_ctl[2].dout == $past(periph_drv[2].dout[6]))
    ) else $error("port b data-in ball mode six not driving");

    a_pull_select: assert property (
        !ctrl_q[0].pull_disable |=>
            pad_ctl[0].pull_en && (pad_ctl[0].pull_up == $past(ctrl_q[0].pull_direction_select))
    ) else $error("pull enable or direction wrong");

    a_pull_inhibit: assert property (
        ctrl_q[1].pull_disable |=> !pad_ctl[1].pull_en && !pad_ctl[1].pull_up
    ) else $error("pull still on while disabled");

    a_oe_override: assert property (
        (ctrl_q[4].oe_force && ctrl_q[4].function_select_field == `PMX_MODE_DEFAULT) |=>
            pad_ctl[4].oe == $past(ctrl_q[4].oe_forced_value)
    ) else $error("output enable does not follow the override");

    a_input_force: assert property (
        (ctrl_q[8].input_force && ctrl_q[8].function_select_field == 4'h1) |=>
            periph_in[8][1] == $past(ctrl_q[8].input_forced_value)
    ) else $error("forced input value not delivered");

    a_slew_follow: assert property (
        ##1 pad_ctl[5].slew_slow == $past(ctrl_q[5].slew_slow_select)
    ) else $error("slew select not passed to the pad");

    a_bad_mode_quiet: assert property (
        (ctrl_q[3].function_select_field != `PMX_MODE_DEFAULT) |=>
            !pad_ctl[3].oe && !pad_ctl[3].dout && (periph_in[3] == '0)
    ) else $error("illegal mode still routes a signal");

    a_strap_capture: assert property (
        $past(rst) |->
            (boot_option_strap_zero == $past(pad_sync[`PMX_BALL_TDO]))
            && (boot_option_strap_one == $past(pad_sync[`PMX_BALL_SYNC_OUT]))
    ) else $error("strap not taken from the last reset cycle");

    a_strap_hold: assert property (
        !$past(rst) |-> $stable(boot_option_strap_zero) && $stable(boot_option_strap_one)
    ) else $error("strap changed after reset");

    a_read_one_cycle: assert property (
        !$past(reg_rd) |-> reg_rdata == '0
    ) else $error("read data outside the answer cycle");

endmodule : pmx_pad_mux

// File: pmx_far_model.sv
// pmx_far_model.sv
// far side of the pad mux: each ball's wire with a weak board drive on it
// assumes pad_ctl comes from the mux and ext_val from the bench
`timescale 1ns/10ps

module pmx_far_model (
    // mux pad controls
    input  wire pmx_pkg::pmx_pad_t [9:0] pad_ctl,
    // weak board drive, one per ball
    input  wire logic [9:0]              ext_val,
    // resolved ball levels
    output      logic [9:0]              level
);
    // ============================================================
    // wire resolution
    // the board drives every ball through a resistor, so a ball never
    // floats, but an enabled pad driver always beats it
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            level[i] = pad_ctl[i].oe ? pad_ctl[i].dout : ext_val[i];
        end
    end
endmodule : pmx_far_model

// File: pmx_pad_mux_tb.sv
// pmx_pad_mux_tb.sv
// self-checking bench: reset state, register port, every mode of every
// ball with random overrides, boot straps across two resets
// assumes pmx_pkg and the far model are compiled first
`timescale 1ns/10ps

module pmx_pad_mux_tb;
    // ============================================================
    // expected tables, ball order as in the mux
    localparam logic [31:0] ADDR [10] = '{32'hffffea00, 32'hffffea1c,
        32'hffffea20, 32'hffffea48, 32'hffffea50, 32'hffffea54,
        32'hffffea58, 32'hffffea5c, 32'hffffea6c, 32'hffffea70};
    localparam logic [10:0] RST_W [10] = '{11'h040, 11'h240, 11'h240,
        11'h140, 11'h040, 11'h040, 11'h240, 11'h1c0, 11'h040, 11'h040};
    localparam logic [15:0] LEGAL [10] = '{16'h0047, 16'h0007, 16'h0047,
        16'h0001, 16'h0107, 16'h0047, 16'h0007, 16'h02c7, 16'h02c3,
        16'h0e03};
    localparam logic [15:0] OUTO [10] = '{16'h0006, 16'h0000, 16'h0040,
        16'h0000, 16'h0104, 16'h0004, 16'h0000, 16'h00c6, 16'h0200, 16'h0002};
    localparam logic [15:0] INO [10] = '{16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0002, 16'h0042, 16'h0006, 16'h0200, 16'h0082, 16'h0200};
    localparam logic [9:0] HAS_PULL = 10'h377;

    // ============================================================
    // signals
    logic                       clk;
    logic                       rst;
    logic [31:0]                reg_addr;
    logic [31:0]                reg_wdata;
    logic                       reg_wr;
    logic                       reg_rd;
    logic [31:0]                reg_rdata;
    pmx_pkg::pmx_periph_t [9:0] periph_drv;
    logic [9:0][15:0]           periph_in;
    logic [9:0]                 pad_level_in;
    pmx_pkg::pmx_pad_t [9:0]    pad_ctl;
    logic                       strap_zero;
    logic                       strap_one;
    logic [9:0]                 ext_val;
    logic [31:0]                exp_q [$];
    logic                       rd_d = 1'b0;
    int                         seed = 32'h6ebcfc72;
    int                         miscompares = 0;
    int                         total_checks = 0;
    int                         cycles = 0;

    pmx_pad_mux u_pmx_pad_mux (
        .clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .periph_drv(periph_drv), .periph_in(periph_in),
        .pad_level_in(pad_level_in), .pad_ctl(pad_ctl),
        .boot_option_strap_zero(strap_zero), .boot_option_strap_one(strap_one)
    );

    pmx_far_model u_pmx_far_model (
        .pad_ctl(pad_ctl), .ext_val(ext_val), .level(pad_level_in)
    );

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ============================================================
    // checking and verdict
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // read data stand only in the cycle after the strobe, so compare there
    always @(posedge clk) begin
        if (rd_d === 1'b1) begin
            check("reg_rdata", reg_rdata, exp_q.pop_front());
        end
        rd_d <= reg_rd;
    end

    // a hang costs a mismatch; the whole run needs about 2000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ============================================================
    // register port: every call sets each strobe once, then one edge
    task automatic bus(input logic [31:0] a, input logic [31:0] dt,
                       input logic w, input logic r);
        reg_addr <= a;
        reg_wdata <= dt;
        reg_wr <= w;
        reg_rd <= r;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] dt);
        bus(a, dt, 1'b1, 1'b0);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 32'h0, 1'b0, 1'b1);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) bus(32'h0, 32'h0, 1'b0, 1'b0);
    endtask : idle

    // straps see the board level while reset is held
    task automatic do_reset(input logic [9:0] v);
        ext_val <= v;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset

    // reset words, pad state and straps right after a reset
    task automatic state_check(input logic z, input logic o);
        for (int b = 0; b < 10; b++) begin
            rd(ADDR[b], 32'(RST_W[b]));
        end
        idle(2);
        @(negedge clk);
        for (int b = 0; b < 10; b++) begin
            check("oe", 32'(pad_ctl[b].oe), 32'(RST_W[b][7]));
            check("pull_en", 32'(pad_ctl[b].pull_en), 32'(HAS_PULL[b] & ~RST_W[b][8]));
            check("pull_up", 32'(pad_ctl[b].pull_up), 32'(RST_W[b][9]));
        end
        check("strap0", 32'(strap_zero), 32'(z));
        check("strap1", 32'(strap_one), 32'(o));
        @(posedge clk);
        $display("test state_check done");
    endtask : state_check

    // ============================================================
    // main sequence
    initial begin
        logic [31:0] wd;
        pmx_pkg::pmx_periph_t d;
        logic [9:0] ev;
        logic oe_e;
        logic lv;
        logic leg;
        logic [15:0] pin;
        rst = 1'b1;
        reg_addr = 32'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        periph_drv = '0;
        ext_val = 10'h080;
        do_reset(10'h080);
        state_check(1'b1, 1'b0);
        // unmapped word: write dropped, read zero, ball zero word untouched
        wr(32'hffffea04, $random(seed));
        rd(32'hffffea04, 32'h0);
        rd(ADDR[0], 32'(RST_W[0]));
        idle(1);
        $display("test unmapped done");
        // every mode of every ball, random overrides, pulls and slew
        for (int b = 0; b < 10; b++) begin
            for (int m = 0; m < 16; m++) begin
                wd = $random(seed);
                wd[3:0] = 4'(m);
                if (INO[b][m]) wd[6] = 1'b0; // forcing an input-only mode on leaves level unknown
                d = $random(seed);
                ev = 10'($random(seed));
                periph_drv[b] <= d;
                ext_val <= ev;
                wr(ADDR[b], wd);
                rd(ADDR[b], wd & 32'h7ff); // upper bits are not stored
                idle(9);
                @(negedge clk);
                leg = LEGAL[b][m];
                oe_e = leg && (wd[6] ? wd[7] : (OUTO[b][m] || (!INO[b][m] && d.doe[m])));
                lv = oe_e ? d.dout[m] : ev[b];
                pin = '0;
                if (leg && !OUTO[b][m]) pin[m] = wd[4] ? wd[5] : lv;
                check("oe", 32'(pad_ctl[b].oe), 32'(oe_e));
                check("dout", 32'(pad_ctl[b].dout), 32'(leg & d.dout[m]));
                check("periph_in", 32'(periph_in[b]), 32'(pin));
                check("pull_en", 32'(pad_ctl[b].pull_en), 32'(HAS_PULL[b] & ~wd[8]));
                if (pad_ctl[b].pull_en === 1'b1)
                    check("pull_up", 32'(pad_ctl[b].pull_up), 32'(wd[9]));
                check("slew", 32'(pad_ctl[b].slew_slow), 32'(wd[10]));
                @(posedge clk);
            end
        end
        $display("test mode_sweep done");
        // straps held through all that ball traffic, then a second reset
        check("strap0", 32'(strap_zero), 32'h1);
        check("strap1", 32'(strap_one), 32'h0);
        do_reset(10'h200);
        ext_val <= 10'h080;
        state_check(1'b0, 1'b1);
        $display("test second_reset done");
        print_verdict();
    end
endmodule : pmx_pad_mux_tb
